// ---- core/mlf_pkg.sv ----
package mlf_pkg;

    // Register map
    localparam logic [7:0] MLF_CFG_OFFSET = 8'h92;
    localparam logic [31:0] MLF_CFG_RESET = 32'h0000_0000;

    // Field positions
    localparam int MLF_OVS_EN_BIT = 30;
    localparam int MLF_BEMF_EN_BIT = 29;
    localparam int MLF_ABS_EN_BIT = 28;
    localparam int MLF_OVS_THR_LSB = 25;
    localparam int MLF_BEMF_THR_LSB = 22;
    localparam int MLF_THR_W = 3;
    localparam int MLF_ACT_LSB = 15;
    localparam int MLF_ACT_W = 4;
    localparam int MLF_RETRY_LSB = 0;
    localparam int MLF_RETRY_W = 3;

    // Current-limit lock action codes
    localparam logic [3:0] MLF_ACT_LATCH_TRI = 4'h0;
    localparam logic [3:0] MLF_ACT_LATCH_RECIRC = 4'h1;
    localparam logic [3:0] MLF_ACT_LATCH_HIGH = 4'h2;
    localparam logic [3:0] MLF_ACT_LATCH_LOW = 4'h3;
    localparam logic [3:0] MLF_ACT_RETRY_TRI = 4'h4;
    localparam logic [3:0] MLF_ACT_RETRY_RECIRC = 4'h5;
    localparam logic [3:0] MLF_ACT_RETRY_HIGH = 4'h6;
    localparam logic [3:0] MLF_ACT_RETRY_LOW = 4'h7;
    localparam logic [3:0] MLF_ACT_REPORT = 4'h8;
    localparam logic [3:0] MLF_ACT_OFF_A = 4'h9;
    localparam logic [3:0] MLF_ACT_OFF_B = 4'ha;

    // Thresholds in tenths of a percent
    localparam logic [11:0] MLF_OVS_BASE = 12'd1300;
    localparam logic [11:0] MLF_OVS_STEP = 12'd100;
    localparam logic [11:0] MLF_BEMF_BASE = 12'd400;
    localparam logic [11:0] MLF_BEMF_STEP = 12'd50;
    localparam logic [11:0] MLF_BEMF_CODE6 = 12'd675;
    localparam logic [11:0] MLF_BEMF_CODE7 = 12'd700;
    localparam logic [15:0] MLF_PCT_SCALE = 16'd1000;

    // Timing
    localparam int MLF_CLK_NS = 25;
    localparam int MLF_RETRY_MS = 100;
    localparam int MLF_RETRY_CYCLES = MLF_RETRY_MS * 1000000 / MLF_CLK_NS;

    typedef enum logic [2:0] {
        MLF_BR_DRIVE,
        MLF_BR_TRISTATE,
        MLF_BR_RECIRC,
        MLF_BR_LOW_BRAKE,
        MLF_BR_HIGH_BRAKE
    } mlf_bridge_t;

endpackage

// ---- core/mlf_thr_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module mlf_thr_decode (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] overspeed_threshold,
    input wire logic [2:0] backemf_lock_threshold,
    output logic [11:0] ovs_tenths,
    output logic [11:0] bemf_tenths
);
    import mlf_pkg::*;

    function automatic logic [11:0] ovs_pct(input logic [2:0] code);
        ovs_pct = MLF_OVS_BASE + 12'(MLF_OVS_STEP * 12'(code));
    endfunction

    // Upper two codes break the 5 percent stride
    function automatic logic [11:0] bemf_pct(input logic [2:0] code);
        unique case (code)
            3'h6: bemf_pct = MLF_BEMF_CODE6;
            3'h7: bemf_pct = MLF_BEMF_CODE7;
            default: bemf_pct = MLF_BEMF_BASE + 12'(MLF_BEMF_STEP * 12'(code));
        endcase
    endfunction

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovs_tenths <= MLF_OVS_BASE;
            bemf_tenths <= MLF_BEMF_BASE;
        end else begin
            ovs_tenths <= ovs_pct(overspeed_threshold);
            bemf_tenths <= bemf_pct(backemf_lock_threshold);
        end
    end

    property p_ovs_map;
        @(posedge clock) disable iff (!rst_n)
        overspeed_threshold == 3'h7 |=> ovs_tenths == 12'd2000;
    endproperty
    a_ovs_map: assert property (p_ovs_map) else $error("overspeed threshold code 7 not 200 percent");

    property p_bemf_map;
        @(posedge clock) disable iff (!rst_n)
        backemf_lock_threshold == 3'h6 |=> bemf_tenths == 12'd675;
    endproperty
    a_bemf_map: assert property (p_bemf_map) else $error("back-emf threshold code 6 not 67.5 percent");

endmodule // mlf_thr_decode
`default_nettype wire

// ---- core/mlf_retry_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module mlf_retry_timer #(
    parameter int CYCLES = 4000000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    output logic done
);
    logic [31:0] count_reg;
    logic run_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h0;
            run_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_reg <= 32'h1;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (count_reg >= 32'(CYCLES)) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg + 32'h1;
                end
            end
        end
    end

endmodule // mlf_retry_timer
`default_nettype wire

// ---- core/mlf_lock_ctl.sv ----
// Function
// - 32-bit config register at 0x92, resets zero
// - Bit 30 enables overspeed lock detector
// - Bit 29 enables back-EMF lock detector
// - Bit 28 enables absent-motor lock detector
// - Bits 27:25 pick overspeed threshold 130-200%
// - Bits 24:22 pick back-EMF threshold 40-70%
// - Action 3 latches fault, low-side brake
// - Actions 4-7 auto-retry, then latch with brake
// - Action 6 latched state brakes high side
// - Actions 9 and 10 ignore current-limit lock
// - Report-only action flags lock, keeps driving
`timescale 1ns/1ps
`default_nettype none
module mlf_lock_ctl #(
    parameter int RETRY_CYCLES = mlf_pkg::MLF_RETRY_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [15:0] speed_now,
    input wire logic [15:0] speed_max,
    input wire logic [15:0] backemf_now,
    input wire logic [15:0] backemf_expected,
    input wire logic motor_absent,
    input wire logic ilimit_lock,
    input wire logic clear_fault,
    output logic overspeed_lock,
    output logic backemf_lock,
    output logic absent_motor_lock,
    output logic ilimit_report,
    output logic fault_indicator_n,
    output mlf_pkg::mlf_bridge_t bridge_state,
    output logic [2:0] retries_used
);
    import mlf_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_RETRY_WAIT, ST_LATCHED} mlf_state_t;

    logic [31:0] cfg_reg;
    mlf_state_t state_reg;
    mlf_state_t state_next;
    logic [11:0] ovs_tenths;
    logic [11:0] bemf_tenths;
    logic timer_start;
    logic timer_done;
    logic [3:0] act;
    logic [2:0] retry_limit;
    logic cfg_hit;

    assign cfg_hit = reg_addr == MLF_CFG_OFFSET;
    assign act = cfg_reg[MLF_ACT_LSB +: MLF_ACT_W];
    assign retry_limit = cfg_reg[MLF_RETRY_LSB +: MLF_RETRY_W];

    function automatic logic act_latch(input logic [3:0] a);
        act_latch = a <= MLF_ACT_LATCH_LOW;
    endfunction

    function automatic logic act_retry(input logic [3:0] a);
        act_retry = a >= MLF_ACT_RETRY_TRI && a <= MLF_ACT_RETRY_LOW;
    endfunction

    // Low two bits pick the brake flavour in both latch and retry groups
    function automatic mlf_bridge_t brake_of(input logic [3:0] a);
        unique case (a[1:0])
            2'h0: brake_of = MLF_BR_TRISTATE;
            2'h1: brake_of = MLF_BR_RECIRC;
            2'h2: brake_of = MLF_BR_HIGH_BRAKE;
            2'h3: brake_of = MLF_BR_LOW_BRAKE;
        endcase
    endfunction

    // Register port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= MLF_CFG_RESET;
        end else if (reg_wr && cfg_hit) begin
            cfg_reg <= reg_wdata;
        end
    end

    // Unmapped offsets read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= cfg_hit ? cfg_reg : 32'h0;
        end
    end

    mlf_thr_decode u_thr (
        .clock(clock),
        .rst_n(rst_n),
        .overspeed_threshold(cfg_reg[MLF_OVS_THR_LSB +: MLF_THR_W]),
        .backemf_lock_threshold(cfg_reg[MLF_BEMF_THR_LSB +: MLF_THR_W]),
        .ovs_tenths(ovs_tenths),
        .bemf_tenths(bemf_tenths)
    );

    // Scaled compares avoid a divider; products fit in 32 bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overspeed_lock <= 1'b0;
            backemf_lock <= 1'b0;
            absent_motor_lock <= 1'b0;
        end else begin
            overspeed_lock <= cfg_reg[MLF_OVS_EN_BIT] &&
                32'(speed_now) * 32'(MLF_PCT_SCALE) > 32'(speed_max) * 32'(ovs_tenths);
            backemf_lock <= cfg_reg[MLF_BEMF_EN_BIT] &&
                32'(backemf_now) * 32'(MLF_PCT_SCALE) < 32'(backemf_expected) * 32'(bemf_tenths);
            absent_motor_lock <= cfg_reg[MLF_ABS_EN_BIT] && motor_absent;
        end
    end

    // Current-limit lock sequencing
    always_comb begin
        state_next = state_reg;
        timer_start = 1'b0;
        unique case (state_reg)
            ST_RUN: begin
                if (ilimit_lock) begin
                    if (act_latch(act)) begin
                        state_next = ST_LATCHED;
                    end else if (act_retry(act)) begin
                        if (retries_used >= retry_limit) begin
                            state_next = ST_LATCHED;
                        end else begin
                            state_next = ST_RETRY_WAIT;
                            timer_start = 1'b1;
                        end
                    end
                end
            end
            ST_RETRY_WAIT: begin
                if (timer_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_LATCHED: begin
                if (clear_fault) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    mlf_retry_timer #(
        .CYCLES(RETRY_CYCLES)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(timer_start),
        .done(timer_done)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            fault_indicator_n <= 1'b1;
            bridge_state <= MLF_BR_DRIVE;
        end else begin
            state_reg <= state_next;
            fault_indicator_n <= state_next == ST_RUN;
            bridge_state <= state_next == ST_RUN ? MLF_BR_DRIVE : brake_of(act);
        end
    end

    // Retry budget refills only when software clears the fault
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retries_used <= 3'h0;
        end else if (clear_fault) begin
            retries_used <= 3'h0;
        end else if (timer_start) begin
            retries_used <= retries_used + 3'h1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ilimit_report <= 1'b0;
        end else if (state_reg == ST_RUN && ilimit_lock && act == MLF_ACT_REPORT) begin
            ilimit_report <= 1'b1;
        end else if (clear_fault) begin
            ilimit_report <= 1'b0;
        end
    end
    // Codes 9, 10 and above fall through every branch: no action

    property p_reset_zero;
        @(posedge clock) disable iff (!rst_n)
        !$past(rst_n) |-> cfg_reg == 32'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

    property p_cfg_write;
        @(posedge clock) disable iff (!rst_n)
        reg_wr && reg_addr == 8'h92 |=> cfg_reg == $past(reg_wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not stored");

    property p_ovs_gate;
        @(posedge clock) disable iff (!rst_n)
        !cfg_reg[30] |=> !overspeed_lock;
    endproperty
    a_ovs_gate: assert property (p_ovs_gate) else $error("overspeed lock while disabled");

    property p_bemf_gate;
        @(posedge clock) disable iff (!rst_n)
        !cfg_reg[29] |=> !backemf_lock;
    endproperty
    a_bemf_gate: assert property (p_bemf_gate) else $error("back-emf lock while disabled");

    property p_absent_gate;
        @(posedge clock) disable iff (!rst_n)
        cfg_reg[28] && motor_absent |=> absent_motor_lock;
    endproperty
    a_absent_gate: assert property (p_absent_gate) else $error("absent motor not flagged");

    sequence s_low_latch_entry;
        state_reg == ST_RUN && ilimit_lock && act == 4'h3;
    endsequence

    sequence s_low_brake_held;
        (!fault_indicator_n && bridge_state == MLF_BR_LOW_BRAKE)[*2];
    endsequence

    property p_low_latch;
        @(posedge clock) disable iff (!rst_n)
        s_low_latch_entry ##1 (!clear_fault && act == 4'h3) |-> s_low_brake_held;
    endproperty
    a_low_latch: assert property (p_low_latch) else $error("action 3 did not latch low brake");

    property p_retry_clears;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RETRY_WAIT && timer_done |=> fault_indicator_n && bridge_state == MLF_BR_DRIVE;
    endproperty
    a_retry_clears: assert property (p_retry_clears) else $error("fault not cleared after retry");

    property p_retry_cap;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RUN && ilimit_lock && act == 4'h4 && retries_used >= retry_limit
        |=> state_reg == ST_LATCHED && bridge_state == MLF_BR_TRISTATE;
    endproperty
    a_retry_cap: assert property (p_retry_cap) else $error("retry cap not latched tristate");

    property p_high_brake;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_LATCHED && act == 4'h6 && !clear_fault |=> bridge_state == MLF_BR_HIGH_BRAKE;
    endproperty
    a_high_brake: assert property (p_high_brake) else $error("action 6 latch not high brake");

    property p_disabled;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RUN && (act == 4'h9 || act == 4'ha)
        |=> state_reg == ST_RUN && fault_indicator_n && !$rose(ilimit_report);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled action reacted to lock");

    property p_report_only;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RUN && ilimit_lock && act == 4'h8
        |=> ilimit_report && fault_indicator_n && bridge_state == MLF_BR_DRIVE;
    endproperty
    a_report_only: assert property (p_report_only) else $error("report-only took action");

    property p_read_data;
        @(posedge clock) disable iff (!rst_n)
        reg_rd && cfg_hit |=> reg_rdata == $past(cfg_reg);
    endproperty
    a_read_data: assert property (p_read_data) else $error("config read-back mismatch");

    property p_read_unmapped;
        @(posedge clock) disable iff (!rst_n)
        reg_rd && !cfg_hit |=> reg_rdata == 32'h0;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

    property p_latch_entry;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RUN && ilimit_lock && act_latch(act) |=> state_reg == ST_LATCHED && !fault_indicator_n;
    endproperty
    a_latch_entry: assert property (p_latch_entry) else $error("latch action did not latch");

    property p_latch_holds;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_LATCHED && !clear_fault |=> state_reg == ST_LATCHED && !fault_indicator_n;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latched fault released without clear");

    property p_retry_start;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RUN && ilimit_lock && act_retry(act) && retries_used < retry_limit && !clear_fault
        |=> state_reg == ST_RETRY_WAIT && !fault_indicator_n && retries_used == $past(retries_used) + 3'h1;
    endproperty
    a_retry_start: assert property (p_retry_start) else $error("retry not started or not counted");

    property p_ignored_lock;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_RUN && ilimit_lock && act >= MLF_ACT_OFF_A
        |=> state_reg == ST_RUN && fault_indicator_n && bridge_state == MLF_BR_DRIVE && !$rose(ilimit_report);
    endproperty
    a_ignored_lock: assert property (p_ignored_lock) else $error("ignored lock caused action");

endmodule // mlf_lock_ctl
`default_nettype wire

// ---- dv/mlf_motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mlf_motor_model (
    input wire logic clock,
    input wire mlf_pkg::mlf_bridge_t bridge_state,
    input wire logic stall,
    input wire logic [15:0] spd,
    input wire logic [15:0] emf,
    input wire logic gone,
    output logic [15:0] speed_now,
    output logic [15:0] backemf_now,
    output logic motor_absent,
    output logic ilimit_lock
);
    import mlf_pkg::*;
    initial begin
        speed_now = 16'h0000;
        backemf_now = 16'h0000;
        motor_absent = 1'h0;
        ilimit_lock = 1'h0;
    end
    // Stalled rotor pulls limit current only while the bridge drives it
    // Rising-edge update keeps the bench's falling-edge stimulus race free
    always @(posedge clock) begin
        ilimit_lock <= stall && (bridge_state == MLF_BR_DRIVE);
        speed_now <= spd;
        backemf_now <= emf;
        motor_absent <= gone;
    end
endmodule // mlf_motor_model
`default_nettype wire

// ---- dv/motor_lock_fault_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module motor_lock_fault_config_tb;
    import mlf_pkg::*;
    localparam int RC = 20;
    localparam mlf_bridge_t BRK [4] = '{MLF_BR_TRISTATE, MLF_BR_RECIRC, MLF_BR_HIGH_BRAKE, MLF_BR_LOW_BRAKE};
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic clear_fault = 1'h0;
    logic stall = 1'h0;
    logic gone = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] got;
    logic [15:0] spd = 16'h0000;
    logic [15:0] emf = 16'h00c8;
    logic [15:0] speed_max = 16'h0064;
    logic [15:0] backemf_expected = 16'h00c8;
    logic [15:0] speed_now;
    logic [15:0] backemf_now;
    logic motor_absent, ilimit_lock, overspeed_lock, backemf_lock, absent_motor_lock, ilimit_report;
    logic fault_indicator_n;
    mlf_bridge_t bridge_state;
    logic [2:0] retries_used;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;

    always #12.5 clock = ~clock;

    mlf_lock_ctl #(.RETRY_CYCLES(RC)) dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .speed_now(speed_now),
        .speed_max(speed_max), .backemf_now(backemf_now), .backemf_expected(backemf_expected),
        .motor_absent(motor_absent), .ilimit_lock(ilimit_lock), .clear_fault(clear_fault),
        .overspeed_lock(overspeed_lock), .backemf_lock(backemf_lock), .absent_motor_lock(absent_motor_lock),
        .ilimit_report(ilimit_report), .fault_indicator_n(fault_indicator_n), .bridge_state(bridge_state),
        .retries_used(retries_used));

    mlf_motor_model motor (.clock(clock), .bridge_state(bridge_state), .stall(stall), .spd(spd), .emf(emf),
        .gone(gone), .speed_now(speed_now), .backemf_now(backemf_now), .motor_absent(motor_absent),
        .ilimit_lock(ilimit_lock));

    task automatic end_of_test;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Ceiling far above the run's roughly seven hundred cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        tick(1);
        reg_wr = 1'h0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr = a;
        reg_rd = 1'h1;
        tick(1);
        reg_rd = 1'h0;
        tick(1);
        d = reg_rdata;
    endtask

    function automatic logic [31:0] cfgw(input logic [2:0] en, input logic [2:0] ot, input logic [2:0] bt,
                                         input logic [3:0] act, input logic [2:0] lim);
        return {1'h0, en, ot, bt, 3'h0, act, 12'h000, lim}; // Reserved bit kept zero
    endfunction

    task automatic clr;
        stall = 1'h0;
        tick(2);
        clear_fault = 1'h1;
        tick(1);
        clear_fault = 1'h0;
        tick(2);
    endtask

    task automatic t_regs;
        rd(8'h92, got);
        chk(got, 32'h0);
        chk(fault_indicator_n, 1'h1);
        wr(8'h92, 32'h7fff_ffff);
        wr(8'h91, 32'h0);
        rd(8'h92, got);
        chk(got, 32'h7fff_ffff);
        rd(8'h91, got);
        chk(got, 32'h0);
        wr(8'h92, 32'h2aaa_aaaa);
        rd(8'h92, got);
        chk(got, 32'h2aaa_aaaa);
    endtask

    task automatic t_detect;
        int thr;
        wr(8'h92, cfgw(3'h0, 3'h7, 3'h7, 4'h9, 3'h0));
        spd = 16'hffff;
        emf = 16'h0000;
        gone = 1'h1;
        tick(3);
        chk(overspeed_lock, 1'h0);
        chk(backemf_lock, 1'h0);
        chk(absent_motor_lock, 1'h0);
        wr(8'h92, cfgw(3'h7, 3'h7, 3'h7, 4'h9, 3'h0));
        tick(3);
        chk(overspeed_lock, 1'h1);
        chk(backemf_lock, 1'h1);
        chk(absent_motor_lock, 1'h1);
        for (int c = 0; c < 8; c++) begin
            wr(8'h92, cfgw(3'h7, 3'(c), 3'(c), 4'h9, 3'h0));
            thr = (c == 6) ? 135 : (c == 7) ? 140 : 80 + 10 * c;
            spd = 16'(130 + 10 * c);
            emf = 16'(thr);
            tick(3);
            chk(overspeed_lock, 1'h0);
            chk(backemf_lock, 1'h0);
            spd = 16'(131 + 10 * c);
            emf = 16'(thr - 1);
            tick(3);
            chk(overspeed_lock, 1'h1);
            chk(backemf_lock, 1'h1);
        end
        gone = 1'h0;
    endtask

    task automatic t_latch;
        for (int i = 0; i < 4; i++) begin
            wr(8'h92, cfgw(3'h0, 3'h0, 3'h0, 4'(i), 3'h0));
            clr();
            stall = 1'h1;
            tick(3);
            chk(fault_indicator_n, 1'h0);
            chk(32'(bridge_state), 32'(BRK[i]));
            tick(RC + 5);
            chk(fault_indicator_n, 1'h0);
            clr();
            chk(fault_indicator_n, 1'h1);
            chk(32'(bridge_state), 32'(MLF_BR_DRIVE));
        end
    endtask

    task automatic t_retry;
        int n;
        for (int i = 0; i < 4; i++) begin
            wr(8'h92, cfgw(3'h0, 3'h0, 3'h0, 4'(4 + i), 3'h1));
            clr();
            stall = 1'h1;
            tick(3);
            chk(fault_indicator_n, 1'h0);
            chk(32'(bridge_state), 32'(BRK[i]));
            chk(retries_used, 3'h1);
            n = 0;
            while (fault_indicator_n !== 1'h1 && n < RC + 10) begin
                tick(1);
                n++;
            end
            chk(32'(n >= RC - 2 && n <= RC + 2), 32'h1);
            chk(32'(bridge_state), 32'(MLF_BR_DRIVE));
            tick(3);
            chk(fault_indicator_n, 1'h0);
            chk(32'(bridge_state), 32'(BRK[i]));
            tick(RC + 5);
            chk(fault_indicator_n, 1'h0);
        end
    endtask

    task automatic t_ignore;
        for (int i = 9; i < 16; i++) begin
            wr(8'h92, cfgw(3'h0, 3'h0, 3'h0, 4'(i), 3'h0));
            clr();
            stall = 1'h1;
            tick(RC);
            chk(fault_indicator_n, 1'h1);
            chk(32'(bridge_state), 32'(MLF_BR_DRIVE));
            chk(ilimit_report, 1'h0);
        end
        wr(8'h92, cfgw(3'h0, 3'h0, 3'h0, 4'h8, 3'h0));
        clr();
        stall = 1'h1;
        tick(3);
        chk(ilimit_report, 1'h1);
        chk(fault_indicator_n, 1'h1);
        chk(32'(bridge_state), 32'(MLF_BR_DRIVE));
        stall = 1'h0;
        tick(3);
        chk(ilimit_report, 1'h1);
    endtask

    initial begin
        tick(2);
        rst_n = 1'h1;
        tick(1);
        t_regs();
        t_detect();
        t_latch();
        t_retry();
        t_ignore();
        end_of_test();
    end
endmodule // motor_lock_fault_config_tb
`default_nettype wire
